// File: flash_cfg_regs.sv
`include "flash_cfg_defines.svh"
module flash_cfg_regs (
    // Clock and reset
    input wire logic ref_clk_i,
    input wire logic nrst_i,
    // Serial link pins
    input wire logic sclk_i,
    input wire logic chip_sel_n_i,
    input wire logic dev_rst_n_i,
    input wire logic dq0_i,
    output logic dq1_o,
    output logic dq1_oe_o,
    // Memory core read side
    input wire logic [1:0] ext_addr_seg_i,
    input wire logic read_start_i,
    input wire logic [31:0] read_addr_i,
    input wire logic read_advance_i,
    output logic [`FCFG_ARRAY_AW-1:0] read_addr_o,
    // Internal configuration
    output logic addr_four_byte_o,
    output logic dual_protocol_o,
    output logic quad_protocol_o,
    output logic [3:0] dummy_cycles_o,
    output logic execute_in_place_mode_o,
    output logic [1:0] wrap_mode_o,
    // Register contents
    output logic [15:0] persistent_config_o,
    output logic [7:0] volatile_config_o
);
    // Dummy code zero acts as the default code
    function automatic logic [3:0] dummy_dec(input logic [3:0] code);
        return (code == 4'h0) ? `FCFG_DUMMY_ALIAS : code;
    endfunction

    logic [3:0] meta_q; // First synchroniser stage
    logic [3:0] sync_q; // Second synchroniser stage
    logic [3:0] prev_q; // Delayed copy for edges
    logic sclk_rise; // Link clock rising edge
    logic sclk_fall; // Link clock falling edge
    logic selected; // Chip select active and device reset pin high
    logic cs_rise; // Frame end
    logic rst_held; // Device reset pin held low
    logic data_bit; // Synchronised data in
    flash_cfg_pkg::link_state_e state_q; // Link phase
    logic [4:0] bit_cnt_q; // Bits this frame, saturating
    logic [15:0] shift_q; // Input shifter
    logic [15:0] out_q; // Output shifter
    logic oe_q; // Output driven
    logic wr_nv_q; // Frame targets persistent register
    logic [7:0] opcode; // Opcode as it completes
    logic boot_q; // One cycle after power reset
    logic vol_commit; // Volatile write completes
    logic nv_commit; // Persistent write completes
    logic [15:0] persistent_q; // Persistent register
    logic [7:0] volatile_q; // Volatile register
    logic cfg_addr4_q; // Internal: four-byte addressing
    logic cfg_dual_n_q; // Internal: dual disabled
    logic cfg_quad_n_q; // Internal: quad disabled
    logic [3:0] cfg_dummy_q; // Internal: dummy cycles
    logic cfg_xip_q; // Internal: execute in place on
    logic [1:0] cfg_wrap_q; // Internal: wrap code

    fcfg_seq_if seq_bus ();

    // Two-flop synchronisers plus edge stage
    always_ff @(posedge ref_clk_i or negedge nrst_i) begin
        if (!nrst_i) begin
            meta_q <= 4'ha; // Idle pin levels, so no false edge after reset
            sync_q <= 4'ha;
            prev_q <= 4'ha;
        end else begin
            meta_q <= {dev_rst_n_i, dq0_i, chip_sel_n_i, sclk_i};
            sync_q <= meta_q;
            prev_q <= sync_q;
        end
    end

    assign sclk_rise = sync_q[0] & ~prev_q[0];
    assign sclk_fall = ~sync_q[0] & prev_q[0];
    assign selected = ~sync_q[1] & sync_q[3];
    assign cs_rise = sync_q[1] & ~prev_q[1];
    assign rst_held = ~sync_q[3];
    assign data_bit = sync_q[2];
    assign opcode = {shift_q[6:0], data_bit};

    // Frame commits, checked at chip select release
    assign vol_commit = cs_rise && !rst_held && state_q == flash_cfg_pkg::LS_WRITE && !wr_nv_q
        && bit_cnt_q == `FCFG_VOL_WR_BITS;
    assign nv_commit = cs_rise && !rst_held && state_q == flash_cfg_pkg::LS_WRITE && wr_nv_q
        && bit_cnt_q == `FCFG_NV_WR_BITS;

    // Input shifter, bit count and command decode
    always_ff @(posedge ref_clk_i or negedge nrst_i) begin
        if (!nrst_i) begin
            state_q <= flash_cfg_pkg::LS_CMD;
            bit_cnt_q <= 5'h0;
            shift_q <= 16'h0;
            wr_nv_q <= 1'b0;
        end else if (!selected) begin
            // Idle between frames
            state_q <= flash_cfg_pkg::LS_CMD;
            bit_cnt_q <= 5'h0;
        end else if (sclk_rise) begin
            shift_q <= {shift_q[14:0], data_bit};
            if (bit_cnt_q != 5'h1f) begin
                bit_cnt_q <= bit_cnt_q + 5'h1;
            end
            if (state_q == flash_cfg_pkg::LS_CMD && bit_cnt_q == 5'h7) begin
                // Dedicated register commands
                if (opcode == `FCFG_OP_WR_VOL || opcode == `FCFG_OP_WR_NV) begin
                    state_q <= flash_cfg_pkg::LS_WRITE;
                end else if (opcode == `FCFG_OP_RD_VOL || opcode == `FCFG_OP_RD_NV) begin
                    state_q <= flash_cfg_pkg::LS_READ;
                end else begin
                    state_q <= flash_cfg_pkg::LS_IGNORE;
                end
                wr_nv_q <= (opcode == `FCFG_OP_WR_NV);
            end
        end
    end

    // Read data: load at opcode, rotate on falling edges
    always_ff @(posedge ref_clk_i or negedge nrst_i) begin
        if (!nrst_i) begin
            out_q <= 16'h0;
            oe_q <= 1'b0;
        end else if (!selected) begin
            oe_q <= 1'b0;
        end else if (sclk_rise && state_q == flash_cfg_pkg::LS_CMD && bit_cnt_q == 5'h7) begin
            if (opcode == `FCFG_OP_RD_NV) begin
                out_q <= persistent_q;
            end else begin
                out_q <= {volatile_q, volatile_q};
            end
        end else if (sclk_fall && state_q == flash_cfg_pkg::LS_READ) begin
            oe_q <= 1'b1;
            if (oe_q) begin
                out_q <= {out_q[14:0], out_q[15]};
            end
        end
    end

    assign dq1_o = out_q[15];
    assign dq1_oe_o = oe_q;

    // Boot marker: load internal configuration after power reset
    always_ff @(posedge ref_clk_i or negedge nrst_i) begin
        if (!nrst_i) begin
            boot_q <= 1'b1;
        end else begin
            boot_q <= 1'b0;
        end
    end

    // Persistent register, kept across device resets
    always_ff @(posedge ref_clk_i or negedge nrst_i) begin
        if (!nrst_i) begin
            persistent_q <= `FCFG_NV_RESET;
        end else if (nv_commit) begin
            persistent_q <= shift_q;
        end
    end

    // Volatile register; reserved bit forced low
    always_ff @(posedge ref_clk_i or negedge nrst_i) begin
        if (!nrst_i) begin
            volatile_q <= `FCFG_VOL_RESET;
        end else if (rst_held) begin
            volatile_q <= `FCFG_VOL_RESET;
        end else if (vol_commit) begin
            volatile_q <= shift_q[7:0];
            volatile_q[`FCFG_VOL_RSVD_BIT] <= 1'b0;
        end
    end

    // Internal configuration
    always_ff @(posedge ref_clk_i or negedge nrst_i) begin
        if (!nrst_i) begin
            cfg_addr4_q <= 1'b0;
            cfg_dual_n_q <= 1'b1;
            cfg_quad_n_q <= 1'b1;
            cfg_dummy_q <= `FCFG_DUMMY_ALIAS;
            cfg_xip_q <= 1'b0;
            cfg_wrap_q <= `FCFG_WRAP_CONT;
        end else if (rst_held || boot_q) begin
            // Download from the persistent register; wrap code set to continuous
            cfg_addr4_q <= ~persistent_q[`FCFG_NV_ADDR_BIT];
            cfg_dual_n_q <= persistent_q[`FCFG_NV_DUAL_BIT];
            cfg_quad_n_q <= persistent_q[`FCFG_NV_QUAD_BIT];
            cfg_dummy_q <= dummy_dec(persistent_q[`FCFG_NV_DUMMY_MSB:`FCFG_NV_DUMMY_LSB]);
            cfg_xip_q <= persistent_q[`FCFG_NV_XIP_MSB:`FCFG_NV_XIP_LSB] != `FCFG_XIP_OFF;
            cfg_wrap_q <= `FCFG_WRAP_CONT;
        end else if (vol_commit) begin
            // Download from the completed volatile write
            cfg_dummy_q <= dummy_dec(shift_q[`FCFG_VOL_DUMMY_MSB:`FCFG_VOL_DUMMY_LSB]);
            cfg_xip_q <= ~shift_q[`FCFG_VOL_XIP_BIT];
            cfg_wrap_q <= shift_q[`FCFG_VOL_WRAP_MSB:`FCFG_VOL_WRAP_LSB];
        end
    end

    assign addr_four_byte_o = cfg_addr4_q;
    assign dual_protocol_o = ~cfg_dual_n_q;
    assign quad_protocol_o = ~cfg_quad_n_q & ~cfg_dual_n_q;
    assign dummy_cycles_o = cfg_dummy_q;
    assign execute_in_place_mode_o = cfg_xip_q;
    assign wrap_mode_o = cfg_wrap_q;
    assign persistent_config_o = persistent_q;
    assign volatile_config_o = volatile_q;

    // Start address: segment from extended register only in 3-byte mode
    assign seq_bus.start = read_start_i;
    assign seq_bus.start_addr = cfg_addr4_q ? read_addr_i[`FCFG_ARRAY_AW-1:0]
        : {ext_addr_seg_i, read_addr_i[`FCFG_SEG_AW-1:0]};
    assign seq_bus.advance = read_advance_i;
    assign seq_bus.wrap = cfg_wrap_q;
    assign read_addr_o = seq_bus.addr;

    read_addr_seq u_seq (
        .ref_clk_i(ref_clk_i),
        .nrst_i(nrst_i),
        .seq(seq_bus.gen)
    );

    default clocking cb @(posedge ref_clk_i); endclocking
    default disable iff (!nrst_i);

    // A completed volatile write frame
    sequence s_vol_done;
        vol_commit;
    endsequence

    property p_vol_commit;
        s_vol_done |=> dummy_cycles_o == dummy_dec($past(shift_q[7:4]));
    endproperty
    a_vol_commit: assert property (p_vol_commit) else $error("dummy not updated");

    property p_dummy_nonzero;
        dummy_cycles_o != 4'h0;
    endproperty
    a_dummy_nonzero: assert property (p_dummy_nonzero) else $error("dummy count zero");

    property p_xip;
        s_vol_done |=> execute_in_place_mode_o == !$past(shift_q[3]);
    endproperty
    a_xip: assert property (p_xip) else $error("execute in place wrong");

    property p_wrap;
        s_vol_done |=> wrap_mode_o == $past(shift_q[1:0]) ##1 seq_bus.wrap == wrap_mode_o;
    endproperty
    a_wrap: assert property (p_wrap) else $error("wrap code wrong");

    property p_rsvd;
        s_vol_done |=> volatile_q == {$past(shift_q[7:3]), 1'b0, $past(shift_q[1:0])};
    endproperty
    a_rsvd: assert property (p_rsvd) else $error("reserved bit stored");

    property p_reload;
        rst_held |=> addr_four_byte_o == !$past(persistent_q[0])
            && dummy_cycles_o == dummy_dec($past(persistent_q[15:12]));
    endproperty
    a_reload: assert property (p_reload) else $error("reset download wrong");

    property p_addr_len;
        boot_q |=> addr_four_byte_o != $past(persistent_q[0]);
    endproperty
    a_addr_len: assert property (p_addr_len) else $error("address length wrong");

    property p_quad;
        rst_held && persistent_q[3:2] == 2'h0 |=> quad_protocol_o;
    endproperty
    a_quad: assert property (p_quad) else $error("quad protocol not on");

    property p_seg;
        read_start_i && !addr_four_byte_o |=> read_addr_o[25:24] == $past(ext_addr_seg_i);
    endproperty
    a_seg: assert property (p_seg) else $error("segment not applied");

    property p_seg_ignored;
        read_start_i && addr_four_byte_o |=> read_addr_o == $past(read_addr_i[25:0]);
    endproperty
    a_seg_ignored: assert property (p_seg_ignored) else $error("segment not ignored");
endmodule

// File: flash_cfg_defines.svh
`ifndef FLASH_CFG_DEFINES_SVH
`define FLASH_CFG_DEFINES_SVH

// Command codes on the serial link
`define FCFG_OP_RD_VOL 8'h85
`define FCFG_OP_WR_VOL 8'h81
`define FCFG_OP_RD_NV 8'hb5
`define FCFG_OP_WR_NV 8'hb1

// Register reset values
`define FCFG_NV_RESET 16'hffff
`define FCFG_VOL_RESET 8'hfb

// Persistent register field positions
`define FCFG_NV_ADDR_BIT 0
`define FCFG_NV_DUAL_BIT 2
`define FCFG_NV_QUAD_BIT 3
`define FCFG_NV_XIP_MSB 11
`define FCFG_NV_XIP_LSB 9
`define FCFG_NV_DUMMY_MSB 15
`define FCFG_NV_DUMMY_LSB 12

// Volatile register field positions
`define FCFG_VOL_DUMMY_MSB 7
`define FCFG_VOL_DUMMY_LSB 4
`define FCFG_VOL_XIP_BIT 3
`define FCFG_VOL_RSVD_BIT 2
`define FCFG_VOL_WRAP_MSB 1
`define FCFG_VOL_WRAP_LSB 0

// Field codes
`define FCFG_XIP_OFF 3'h7
`define FCFG_DUMMY_ALIAS 4'hf
`define FCFG_WRAP_CONT 2'h3

// Link bit counts: opcode, then data
`define FCFG_VOL_WR_BITS 5'h10
`define FCFG_NV_WR_BITS 5'h18

// Array address width and segment width
`define FCFG_ARRAY_AW 26
`define FCFG_SEG_AW 24

`endif

// File: flash_cfg_pkg.sv
package flash_cfg_pkg;
    // Link command phase
    typedef enum logic [1:0] {
        LS_CMD,
        LS_WRITE,
        LS_READ,
        LS_IGNORE
    } link_state_e;
endpackage

// File: fcfg_seq_if.sv
`include "flash_cfg_defines.svh"
interface fcfg_seq_if;
    logic start; // Load start address
    logic [`FCFG_ARRAY_AW-1:0] start_addr; // Formed start address
    logic advance; // Step to next byte
    logic [1:0] wrap; // Wrap code
    logic [`FCFG_ARRAY_AW-1:0] addr; // Current read address
    modport ctrl (output start, output start_addr, output advance, output wrap, input addr);
    modport gen (input start, input start_addr, input advance, input wrap, output addr);
endinterface

// File: read_addr_seq.sv
`include "flash_cfg_defines.svh"
module read_addr_seq (
    // Clock and reset
    input wire logic ref_clk_i,
    input wire logic nrst_i,
    // Sequencer port
    fcfg_seq_if.gen seq
);
    localparam int AW = `FCFG_ARRAY_AW;

    // Block mask for the wrap code
    function automatic logic [AW-1:0] wrap_mask(input logic [1:0] code);
        logic [AW-1:0] m;
        m = '1;
        if (code == 2'h0) begin
            m = AW'(32'h0000_000f);
        end else if (code == 2'h1) begin
            m = AW'(32'h0000_001f);
        end else if (code == 2'h2) begin
            m = AW'(32'h0000_003f);
        end
        return m;
    endfunction

    logic [AW-1:0] addr_q; // Address register
    logic [AW-1:0] mask; // Current block mask
    logic [AW-1:0] inc; // Address plus one

    assign mask = wrap_mask(seq.wrap);
    assign inc = addr_q + AW'(1);
    assign seq.addr = addr_q;

    // Start, then step inside the aligned block
    always_ff @(posedge ref_clk_i or negedge nrst_i) begin
        if (!nrst_i) begin
            addr_q <= '0;
        end else if (seq.start) begin
            addr_q <= seq.start_addr;
        end else if (seq.advance) begin
            addr_q <= (addr_q & ~mask) | (inc & mask);
        end
    end

    default clocking cb @(posedge ref_clk_i); endclocking
    default disable iff (!nrst_i);

    // Start loads the given address
    property p_start_load;
        seq.start |=> addr_q == $past(seq.start_addr);
    endproperty
    a_start_load: assert property (p_start_load) else $error("start address not loaded");

    // Steps stay inside the block and wrap to its first byte
    property p_wrap_step;
        seq.advance && !seq.start && seq.wrap != `FCFG_WRAP_CONT
            |=> ((addr_q & ~$past(mask)) == ($past(addr_q) & ~$past(mask)))
            && ((addr_q & $past(mask)) == (($past(addr_q) + AW'(1)) & $past(mask)));
    endproperty
    a_wrap_step: assert property (p_wrap_step) else $error("wrap step left its block");
endmodule

// File: link_host.sv
// Host side of the serial link: frames bits on sclk, mode 0
module link_host (
    // Serial link pins
    output logic sclk_o,
    output logic chip_sel_n_o,
    output logic dq0_o,
    input wire logic dq1_i
);
    timeunit 1ns;
    timeprecision 100ps;
    // 8 MHz link, below every clock limit and dummy count need
    localparam realtime half_period = 62.5;

    // Idle link: clock low, no frame
    initial begin
        sclk_o = 1'b0;
        chip_sel_n_o = 1'b1;
        dq0_o = 1'b0;
    end

    // One frame: opcode, write bits, then read bits sampled on rise
    task automatic frame(input logic [7:0] op, input logic [15:0] wd, input int wbits,
                         input int rbits, output logic [15:0] rd);
        logic [23:0] sh;
        int i;
        sh = {op, wd};
        rd = 16'h0000;
        chip_sel_n_o = 1'b0;
        #(half_period);
        // Bits change after the fall, MSB first
        for (i = 0; i < 8 + wbits; i++) begin
            dq0_o = sh[23-i];
            #(half_period);
            sclk_o = 1'b1;
            #(half_period);
            sclk_o = 1'b0;
        end
        // Line no longer meaningful: show the inverse
        dq0_o = ~dq0_o;
        for (i = 0; i < rbits; i++) begin
            #(half_period);
            sclk_o = 1'b1;
            rd = {rd[14:0], dq1_i};
            #(half_period);
            sclk_o = 1'b0;
        end
        #(half_period);
        chip_sel_n_o = 1'b1;
        #(half_period * 2);
    endtask
endmodule

// File: flash_read_config_regs_tb.sv
`include "flash_cfg_defines.svh"
// Self-checking bench for the configuration register block
module flash_read_config_regs_tb;
    timeunit 1ns;
    timeprecision 100ps;
    logic ref_clk_i = 1'b0; // System clock
    logic nrst_i = 1'b0; // Power reset
    logic dev_rst_n_i = 1'b1; // Device reset pin
    logic [1:0] ext_addr_seg_i = 2'h1; // Segment for 3-byte reads
    logic read_start_i = 1'b0; // Start pulse
    logic [31:0] read_addr_i = 32'h0; // Start address
    logic read_advance_i = 1'b0; // Step request
    wire sclk, cs_n, dq0, dq1, dq1_oe; // Link wires
    logic [25:0] read_addr_o; // Current address
    logic addr_four_byte_o, dual_protocol_o, quad_protocol_o, execute_in_place_mode_o;
    logic [3:0] dummy_cycles_o; // Dummy count
    logic [1:0] wrap_mode_o; // Wrap code
    logic [15:0] persistent_config_o; // Persistent register
    logic [7:0] volatile_config_o; // Volatile register
    logic [15:0] rd; // Read frame data
    int bad_count = 0; // Mismatches
    int checked = 0; // Comparisons

    // 200 MHz clock
    always #2.5 ref_clk_i = ~ref_clk_i;

    link_host link_host_i (.sclk_o(sclk), .chip_sel_n_o(cs_n), .dq0_o(dq0), .dq1_i(dq1));

    flash_cfg_regs flash_cfg_regs_i (
        .ref_clk_i(ref_clk_i), .nrst_i(nrst_i), .sclk_i(sclk), .chip_sel_n_i(cs_n),
        .dev_rst_n_i(dev_rst_n_i), .dq0_i(dq0), .dq1_o(dq1), .dq1_oe_o(dq1_oe),
        .ext_addr_seg_i(ext_addr_seg_i), .read_start_i(read_start_i),
        .read_addr_i(read_addr_i), .read_advance_i(read_advance_i),
        .read_addr_o(read_addr_o), .addr_four_byte_o(addr_four_byte_o),
        .dual_protocol_o(dual_protocol_o), .quad_protocol_o(quad_protocol_o),
        .dummy_cycles_o(dummy_cycles_o), .execute_in_place_mode_o(execute_in_place_mode_o),
        .wrap_mode_o(wrap_mode_o), .persistent_config_o(persistent_config_o),
        .volatile_config_o(volatile_config_o)
    );

    // Compare and count
    task automatic chk(input string what, input logic [31:0] exp, input logic [31:0] got);
        checked++;
        if (got !== exp) begin
            bad_count++;
            $display("[FAIL] %s expected %h seen %h", what, exp, got);
        end
    endtask

    // Volatile value and the configuration it implies
    task automatic vol_chk(input logic [7:0] v);
        chk("volatile_config", {24'h0, v & 8'hfb}, {24'h0, volatile_config_o});
        chk("dummy_cycles", (v[7:4] == 4'h0) ? 32'hf : 32'(v[7:4]), 32'(dummy_cycles_o));
        chk("xip", {31'h0, ~v[3]}, {31'h0, execute_in_place_mode_o});
        chk("wrap_mode", {30'h0, v[1:0]}, {30'h0, wrap_mode_o});
    endtask

    // Volatile write with a chosen data bit count
    task automatic vol_wr(input logic [7:0] v, input int nbits);
        link_host_i.frame(`FCFG_OP_WR_VOL, {v, 8'h00}, nbits, 0, rd);
        repeat (4) @(posedge ref_clk_i);
        #1;
    endtask

    // Start a read and step it twenty times
    task automatic walk(input logic [1:0] w, input logic [31:0] a, input logic fourb);
        logic [25:0] e;
        logic [25:0] m;
        int i;
        e = fourb ? a[25:0] : {ext_addr_seg_i, a[23:0]};
        m = (26'h10 << w) - 26'h1;
        @(posedge ref_clk_i);
        #1 read_start_i = 1'b1;
        read_addr_i = a;
        @(posedge ref_clk_i);
        #1 read_start_i = 1'b0;
        read_advance_i = 1'b1;
        chk("start_addr", {6'h0, e}, {6'h0, read_addr_o});
        for (i = 0; i < 20; i++) begin
            e = (w == 2'h3) ? e + 26'h1 : ((e & ~m) | ((e + 26'h1) & m));
            @(posedge ref_clk_i);
            #1 chk("read_addr", {6'h0, e}, {6'h0, read_addr_o});
        end
        read_advance_i = 1'b0;
    endtask

    // Counts, verdict, end of run
    task automatic finish_test();
        $display("checks %0d mismatches %0d", checked, bad_count);
        if (bad_count == 0 && checked > 0) begin
            $display("STATUS OK");
        end else begin
            $display("STATUS NOT OK");
        end
        $finish;
    endtask

    // Cut a hang short
    initial begin
        #300us;
        bad_count++;
        finish_test();
    end

    // Test sequence
    initial begin
        logic [7:0] vals [4];
        int k;
        vals = '{8'h5a, 8'h04, 8'he9, 8'h1f};
        repeat (10) @(posedge ref_clk_i);
        #1 nrst_i = 1'b1;
        repeat (8) @(posedge ref_clk_i);
        #1;
        // Reset state
        chk("persistent_config", 32'hffff, {16'h0, persistent_config_o});
        vol_chk(8'hfb);
        chk("addr_four_byte", 32'h0, {31'h0, addr_four_byte_o});
        chk("quad_protocol", 32'h0, {31'h0, quad_protocol_o});
        chk("dq1_oe", 32'h0, {31'h0, dq1_oe});
        $display("test reset done");
        // Every wrap code, dummy alias, reserved bit, read back
        for (k = 0; k < 4; k++) begin
            vol_wr(vals[k], 8);
            vol_chk(vals[k]);
            link_host_i.frame(`FCFG_OP_RD_VOL, 16'h0, 0, 8, rd);
            chk("volatile_read", {24'h0, vals[k] & 8'hfb}, {16'h0, rd});
        end
        $display("test volatile done");
        // Short write frame is dropped
        vol_wr(8'h00, 7);
        vol_chk(8'h1f);
        $display("test refused done");
        // Wrap sequences, 3-byte mode uses the segment
        for (k = 0; k < 4; k++) begin
            vol_wr(8'h38 | k[7:0], 8);
            walk(k[1:0], (k == 3) ? 32'h00ff_fffd : 32'h0012_343d, 1'b0);
        end
        $display("test wrap done");
        // Persistent write applies at next reset only
        link_host_i.frame(`FCFG_OP_WR_NV, 16'hfff2, 16, 0, rd);
        repeat (4) @(posedge ref_clk_i);
        #1;
        chk("persistent_config", 32'hfff2, {16'h0, persistent_config_o});
        chk("addr_four_byte", 32'h0, {31'h0, addr_four_byte_o});
        link_host_i.frame(`FCFG_OP_RD_NV, 16'h0, 0, 16, rd);
        chk("persistent_read", 32'hfff2, {16'h0, rd});
        @(posedge ref_clk_i);
        #1 dev_rst_n_i = 1'b0;
        repeat (6) @(posedge ref_clk_i);
        #1 dev_rst_n_i = 1'b1;
        repeat (8) @(posedge ref_clk_i);
        #1;
        chk("addr_four_byte", 32'h1, {31'h0, addr_four_byte_o});
        chk("quad_protocol", 32'h1, {31'h0, quad_protocol_o});
        chk("dual_protocol", 32'h1, {31'h0, dual_protocol_o});
        vol_chk(8'hfb);
        ext_addr_seg_i = 2'h2;
        walk(2'h3, 32'h03ff_fffe, 1'b1);
        $display("test persistent done");
        finish_test();
    end
endmodule
